//--- tb_top.sv
// self-checking bench for the thermal threshold assist
`timescale 1ns/1ns
module tb_top;
   localparam [9:0] T1 = 10'h3FC, T2 = 10'h3FD, T3 = 10'h3FE;
   reg         clk_sys_i = 1'b0;
   reg         rst_i = 1'b1;
   reg         wr = 1'b0;
   reg         rd = 1'b0;
   reg  [9:0]  num = 10'h000;
   reg         priv = 1'b1;
   reg  [31:0] wdata = 32'h0;
   reg  [31:0] care = 32'hFFFFFFFF;
   reg         mask = 1'b0;
   reg  [7:0]  temp = 8'h3C;
   wire [31:0] rdata;
   wire        hit;
   wire [6:0]  dac;
   wire        above;
   wire        irq;
   integer     mismatches = 0;
   integer     samples_checked = 0;
   always #2 clk_sys_i = ~clk_sys_i;
   tta_top u_tta_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .spr_wr_i(wr), .spr_rd_i(rd), .spr_num_i(num),
      .spr_priv_i(priv), .spr_wdata_i(wdata), .spr_rdata_o(rdata), .spr_hit_o(hit), .dac_threshold_o(dac),
      .temp_above_i(above), .external_interrupt_mask_i(mask), .thermal_irq_o(irq));
   tta_sensor_model u_tta_sensor_model (.temp_i(temp), .threshold_i(dac), .above_o(above));
   // processor bit n sits at vector bit 31-n
   function [31:0] tw(input c, input s, input [6:0] t, input d, input e, input v);
      tw = {c, s, t, 20'h0, d, e, v};
   endfunction
   task chk(input string what, input [31:0] got, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task wr_spr(input [9:0] n, input [31:0] d);
      begin
         @(negedge clk_sys_i);
         wr = 1'b1;
         num = n;
         wdata = d;
         @(negedge clk_sys_i);
         wr = 1'b0;
      end
   endtask
   task rd_spr(input [9:0] n, input [31:0] exp, input string what);
      begin
         @(negedge clk_sys_i);
         rd = 1'b1;
         num = n;
         @(negedge clk_sys_i);
         rd = 1'b0;
         chk(what, rdata & care, exp & care);
         chk("hit", {31'h0, hit}, {31'h0, priv && n >= T1 && n <= T3});
      end
   endtask
   task chk_irq(input e);
      begin
         @(negedge clk_sys_i);
         chk("irq", {31'h0, irq}, {31'h0, e});
      end
   endtask
   // interval 4 keeps each sample well under the settle wait
   task settle;
      repeat (40) @(negedge clk_sys_i);
   endtask
   task results;
      begin
         $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
         if (mismatches == 0 && samples_checked > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   initial begin
      #8000;
      mismatches = mismatches + 1;
      results;
   end
   initial begin
      repeat (5) @(negedge clk_sys_i);
      rst_i = 1'b0;
      rd_spr(T1, 32'h0, "t1 reset");
      chk("dac reset", {25'h0, dac}, 32'h0);
      rd_spr(T3, 32'h0, "ctl reset");
      wr_spr(T3, 32'h9);
      wr_spr(T1, tw(0, 0, 7'h32, 0, 1, 1));
      wr_spr(T2, tw(0, 0, 7'h46, 0, 1, 0));
      settle;
      rd_spr(T1, tw(1, 1, 7'h32, 0, 1, 1), "t1 above");
      chk("dac single", {25'h0, dac}, {25'h0, 7'h32});
      rd_spr(T2, tw(0, 0, 7'h46, 0, 1, 0), "t2 unused");
      chk_irq(1'b0);
      mask = 1'b1;
      chk_irq(1'b1);
      wr_spr(T1, tw(0, 0, 7'h32, 1, 1, 1));
      care = 32'h7FFFFFFF;
      rd_spr(T1, tw(0, 0, 7'h32, 1, 1, 1), "t1 restart");
      care = 32'hFFFFFFFF;
      settle;
      rd_spr(T1, tw(0, 1, 7'h32, 1, 1, 1), "t1 below dir");
      temp = 8'h28;
      settle;
      rd_spr(T1, tw(1, 1, 7'h32, 1, 1, 1), "t1 cold");
      chk_irq(1'b1);
      wr_spr(T1, tw(0, 0, 7'h32, 1, 0, 1));
      settle;
      rd_spr(T1, tw(1, 1, 7'h32, 1, 0, 1), "t1 no irq");
      chk_irq(1'b0);
      wr_spr(T1, tw(0, 0, 7'h32, 0, 1, 1));
      wr_spr(T2, tw(0, 0, 7'h46, 1, 1, 1));
      settle;
      rd_spr(T1, tw(0, 1, 7'h32, 0, 1, 1), "dual t1");
      rd_spr(T2, tw(1, 1, 7'h46, 1, 1, 1), "dual t2");
      chk_irq(1'b1);
      wr_spr(T3, 32'h9);
      care = 32'h7FFFFFFF;
      rd_spr(T2, tw(0, 0, 7'h46, 1, 1, 1), "ctl clears");
      care = 32'hFFFFFFFF;
      settle;
      priv = 1'b0;
      wr_spr(T2, 32'h0);
      rd_spr(T2, 32'h0, "unpriv");
      priv = 1'b1;
      rd_spr(T2, tw(1, 1, 7'h46, 1, 1, 1), "t2 kept");
      rd_spr(10'h3FB, 32'h0, "unmapped");
      wr_spr(T3, 32'h8);
      settle;
      care = 32'h7FFFFFFF;
      rd_spr(T1, tw(0, 0, 7'h32, 0, 1, 1), "cmp off");
      results;
   end
endmodule

//--- tta_props.sv
// port checks for the thermal threshold assist
`timescale 1ns/1ns
module tta_props (
   input wire        clk_sys_i,
   input wire        rst_i,
   input wire        spr_wr_i,
   input wire        spr_rd_i,
   input wire [9:0]  spr_num_i,
   input wire        spr_priv_i,
   input wire [31:0] spr_rdata_o,
   input wire        spr_hit_o,
   input wire        external_interrupt_mask_i,
   input wire        thermal_irq_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   wire map = spr_num_i >= 10'h3FC && spr_num_i <= 10'h3FE;
   wire ctl = spr_num_i == 10'h3FE;
   sequence s_rd; spr_rd_i && spr_priv_i && map; endsequence
   sequence s_ctl_wr; spr_wr_i && spr_priv_i && ctl; endsequence
   chk_irq_masked: assert property (!external_interrupt_mask_i |-> !thermal_irq_o)
      else $error("irq while masked");
   chk_read_hit: assert property (s_rd |=> spr_hit_o)
      else $error("read not answered");
   chk_hit_cause: assert property (spr_hit_o |-> $past(spr_rd_i && spr_priv_i && map))
      else $error("hit without read");
   chk_unpriv_quiet: assert property (spr_rd_i && !spr_priv_i |=> !spr_hit_o && spr_rdata_o == 32'h0)
      else $error("unprivileged read answered");
   chk_idle_rdata: assert property (!spr_rd_i |=> spr_rdata_o == 32'h0)
      else $error("read data not idle");
   chk_ctl_irq_drop: assert property (s_ctl_wr |=> !thermal_irq_o)
      else $error("irq kept after control write");
   chk_thr_reserved: assert property (s_rd ##0 !ctl |=> spr_rdata_o[22:3] == 20'h0)
      else $error("threshold reserved bits set");
   chk_ctl_reserved: assert property (s_rd ##0 ctl |=> spr_rdata_o[31:14] == 18'h0)
      else $error("control reserved bits set");
endmodule
bind tta_top tta_props u_tta_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .spr_wr_i(spr_wr_i), .spr_rd_i(spr_rd_i),
   .spr_num_i(spr_num_i), .spr_priv_i(spr_priv_i), .spr_rdata_o(spr_rdata_o), .spr_hit_o(spr_hit_o),
   .external_interrupt_mask_i(external_interrupt_mask_i), .thermal_irq_o(thermal_irq_o));

//--- tta_regs.vh
// register map, field positions and reset values of the thermal threshold assist
// Notes on behaviour
// - crossing_status sets when the sampled comparison crosses that register's threshold.
// - status_valid sets once crossing_status holds a valid sampled result; read-only.
// - each threshold register holds a 7-bit threshold, 0 to 127 degrees, one per step.
// - compare_direction clear means above threshold; set means below threshold.
// - with irq enable clear, crossing status still updates but no interrupt is raised.
// - the interrupt is taken only while external_interrupt_mask is set.
// - comparison runs only while register valid and control compare enable are both 1.
// - an invalid threshold register is ignored and never compared.
// - writing an active threshold register clears its status_valid and restarts comparison.
// - any control register write clears both status_valid bits and restarts comparison.
// - dual-threshold and single-threshold operation are both supported.
// - interrupt needs valid register, crossing status, status_valid and irq enable all 1.
// - registers are reached only by privileged special-register writes and reads.
// - a 13-bit sample interval sets cycles waited before each comparison sample.
// - compare enable works only if at least one threshold register is valid.
// - in dual-threshold mode the single comparator alternates between both thresholds.
// - threshold first, threshold second and control are registers 1020, 1021, 1022.
`ifndef TTA_REGS_VH
`define TTA_REGS_VH

`define TTA_SPR_THRESH_FIRST  10'h3FC
`define TTA_SPR_THRESH_SECOND 10'h3FD
`define TTA_SPR_CONTROL       10'h3FE

// bit positions in the processor's numbering, bit 0 is the msb
`define TTA_BIT_CROSSING      0
`define TTA_BIT_STATUS_VALID  1
`define TTA_THRESH_MSB        2
`define TTA_THRESH_LSB        8
`define TTA_BIT_DIRECTION     29
`define TTA_BIT_IRQ_ENABLE    30
`define TTA_BIT_REG_VALID     31
`define TTA_INTERVAL_MSB      18
`define TTA_INTERVAL_LSB      30
`define TTA_BIT_CMP_ENABLE    31

`define TTA_THRESH_RESET      7'h00
`define TTA_INTERVAL_RESET    13'h0000
`define TTA_THRESH_W          7
`define TTA_INTERVAL_W        13

`endif

//--- tta_sensor_model.sv
// comparator stand-in for the junction temperature sensor
`timescale 1ns/1ns
module tta_sensor_model (
   input  wire [7:0] temp_i,
   input  wire [6:0] threshold_i,
   output wire       above_o
);
   // ideal and instant, so settling time is not exercised
   assign above_o = temp_i > {1'b0, threshold_i};
endmodule

//--- tta_slot.v
// one threshold register with its comparison result and interrupt qualification
`timescale 1ns/1ns
module tta_slot (
   // clock and reset
   input  wire       clk_sys_i,
   input  wire       rst_i,
   // register write
   input  wire       wr_i,
   input  wire [31:0] wdata_i,
   input  wire       invalidate_i,
   // comparison sample
   input  wire       sample_i,
   input  wire       above_i,
   // state
   output wire       active_o,
   output wire [6:0] threshold_o,
   output wire       irq_o,
   output wire [31:0] rdata_o
);
`include "tta_regs.vh"
   reg [6:0] threshold;
   reg       direction;
   reg       irq_enable;
   reg       reg_valid;
   reg       crossing_status;
   reg       status_valid;

   // processor bit n is vector bit 31-n
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         threshold       <= `TTA_THRESH_RESET;
         direction       <= 1'b0;
         irq_enable      <= 1'b0;
         reg_valid       <= 1'b0;
         crossing_status <= 1'b0;
         status_valid    <= 1'b0;
      end else if (wr_i) begin
         // reserved bits are dropped
         threshold    <= wdata_i[31-`TTA_THRESH_MSB:31-`TTA_THRESH_LSB];
         direction    <= wdata_i[31-`TTA_BIT_DIRECTION];
         irq_enable   <= wdata_i[31-`TTA_BIT_IRQ_ENABLE];
         reg_valid    <= wdata_i[31-`TTA_BIT_REG_VALID];
         status_valid <= 1'b0; // restart
      end else if (invalidate_i) begin
         status_valid <= 1'b0;
      end else if (sample_i && reg_valid) begin
         // direction selects sense
         crossing_status <= direction ? ~above_i : above_i;
         status_valid    <= 1'b1;
      end
   end

   assign active_o    = reg_valid;
   assign threshold_o = threshold;
   assign irq_o       = reg_valid & crossing_status & status_valid & irq_enable;
   // read layout mirrors the write layout, crossing_status in processor bit 0
   assign rdata_o     = {crossing_status, status_valid, threshold, 20'h00000, direction, irq_enable, reg_valid};
endmodule

//--- tta_top.v
// thermal threshold assist: special-register port, sample sequencer, two threshold slots
`timescale 1ns/1ns
module tta_top (
   // clock and reset
   input  wire        clk_sys_i,
   input  wire        rst_i,
   // special-register port from the core
   input  wire        spr_wr_i,
   input  wire        spr_rd_i,
   input  wire [9:0]  spr_num_i,
   input  wire        spr_priv_i,
   input  wire [31:0] spr_wdata_i,
   output reg  [31:0] spr_rdata_o,
   output reg         spr_hit_o,
   // analog comparator
   output reg  [6:0]  dac_threshold_o,
   input  wire        temp_above_i,
   // interrupt
   input  wire        external_interrupt_mask_i,
   output wire        thermal_irq_o
);
`include "tta_regs.vh"
   reg  [12:0] sample_interval;
   reg         cmp_enable;
   reg  [12:0] wait_cnt;
   reg         sel_second;
   reg         restart;
   wire [1:0]  active;
   wire [6:0]  thr_first;
   wire [6:0]  thr_second;
   wire [1:0]  irq;
   wire [31:0] rd_first;
   wire [31:0] rd_second;
   wire        wr_ok;
   wire        rd_ok;
   wire        wr_first;
   wire        wr_second;
   wire        wr_ctrl;
   wire        running;
   wire        sample;
   wire        cur_sel;

   // privileged accesses only
   assign wr_ok     = spr_wr_i & spr_priv_i;
   assign rd_ok     = spr_rd_i & spr_priv_i;
   assign wr_first  = wr_ok & (spr_num_i == `TTA_SPR_THRESH_FIRST);
   assign wr_second = wr_ok & (spr_num_i == `TTA_SPR_THRESH_SECOND);
   assign wr_ctrl   = wr_ok & (spr_num_i == `TTA_SPR_CONTROL);

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         sample_interval <= `TTA_INTERVAL_RESET;
         cmp_enable      <= 1'b0;
      end else if (wr_ctrl) begin
         sample_interval <= spr_wdata_i[31-`TTA_INTERVAL_MSB:31-`TTA_INTERVAL_LSB];
         cmp_enable      <= spr_wdata_i[31-`TTA_BIT_CMP_ENABLE];
      end
   end

   // compare only with enable and at least one valid slot
   assign running = cmp_enable & (active != 2'b00);
   // pick slot: alternate when both valid, else the single valid one
   assign cur_sel = (active == 2'b11) ? sel_second : active[1] & ~active[0];
   // comparator settles through the whole interval before the result is taken
   assign sample  = running & ~restart & (wait_cnt >= sample_interval);

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         wait_cnt   <= 13'h0000;
         sel_second <= 1'b0;
         restart    <= 1'b1;
      end else if (wr_first || wr_second || wr_ctrl || !running) begin
         wait_cnt   <= 13'h0000;
         restart    <= 1'b1;
      end else if (restart) begin
         wait_cnt   <= 13'h0000;
         restart    <= 1'b0;
      end else if (sample) begin
         wait_cnt   <= 13'h0000;
         sel_second <= ~cur_sel;
      end else begin
         wait_cnt   <= wait_cnt + 13'h0001;
      end
   end

   always @(posedge clk_sys_i) begin
      if (rst_i)
         dac_threshold_o <= `TTA_THRESH_RESET;
      else
         dac_threshold_o <= cur_sel ? thr_second : thr_first;
   end

   tta_slot u_first (
      .clk_sys_i    (clk_sys_i),
      .rst_i        (rst_i),
      .wr_i         (wr_first),
      .wdata_i      (spr_wdata_i),
      .invalidate_i (wr_ctrl),
      .sample_i     (sample & ~cur_sel),
      .above_i      (temp_above_i),
      .active_o     (active[0]),
      .threshold_o  (thr_first),
      .irq_o        (irq[0]),
      .rdata_o      (rd_first)
   );

   tta_slot u_second (
      .clk_sys_i    (clk_sys_i),
      .rst_i        (rst_i),
      .wr_i         (wr_second),
      .wdata_i      (spr_wdata_i),
      .invalidate_i (wr_ctrl),
      .sample_i     (sample & cur_sel),
      .above_i      (temp_above_i),
      .active_o     (active[1]),
      .threshold_o  (thr_second),
      .irq_o        (irq[1]),
      .rdata_o      (rd_second)
   );

   // masked by the core's external interrupt enable
   assign thermal_irq_o = (irq[0] | irq[1]) & external_interrupt_mask_i;

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         spr_rdata_o <= 32'h00000000;
         spr_hit_o   <= 1'b0;
      end else begin
         spr_hit_o   <= rd_ok & ((spr_num_i == `TTA_SPR_THRESH_FIRST) | (spr_num_i == `TTA_SPR_THRESH_SECOND) |
                                 (spr_num_i == `TTA_SPR_CONTROL));
         if (rd_ok && spr_num_i == `TTA_SPR_THRESH_FIRST)
            spr_rdata_o <= rd_first;
         else if (rd_ok && spr_num_i == `TTA_SPR_THRESH_SECOND)
            spr_rdata_o <= rd_second;
         else if (rd_ok && spr_num_i == `TTA_SPR_CONTROL)
            spr_rdata_o <= {18'h00000, sample_interval, cmp_enable};
         else
            spr_rdata_o <= 32'h00000000;
      end
   end
endmodule
